/* core/pfm_pkg.sv */
// ****************************************************************
// pad function mux constants
// ****************************************************************
package pfm_pkg;

    // register byte addresses
    localparam logic [31:0] ADDR_PAD_FUNC   = 32'h2013_2020;
    localparam logic [31:0] ADDR_SLOT_EN    = 32'h2013_2024;
    localparam logic [31:0] ADDR_SEL_W0     = 32'h2013_2028;
    localparam logic [31:0] ADDR_SEL_W1     = 32'h2013_202C;
    localparam logic [31:0] ADDR_SEL_W2     = 32'h2013_2030;
    localparam logic [31:0] ADDR_PAD_LEVEL  = 32'h2013_2034;
    localparam logic [31:0] ADDR_PAD_STATE  = 32'h2013_2038;

    // pad_function_enable field positions
    localparam int PAD0_GIO_BIT   = 9;
    localparam int PAD1_GIO_BIT   = 10;
    localparam int PAD12_GIO_BIT  = 11;
    localparam int PAD13_GIO_BIT  = 12;
    localparam int RADIO_BIT      = 13;
    localparam int DBG_LSB        = 16;
    localparam int DBG_W          = 8;

    // writable bits, reserved bits read zero
    localparam logic [31:0] PAD_FUNC_MASK = 32'h00FF_3E00;
    localparam logic [31:0] SLOT_EN_MASK  = 32'h003F_FFFF;
    localparam logic [31:0] SEL_W2_MASK   = 32'h00FF_FFFF;

    // values after reset
    localparam logic [31:0] PAD_FUNC_RST  = 32'h0000_0000;
    localparam logic [31:0] SLOT_EN_RST   = 32'h0000_0000;
    localparam logic [3:0]  SEL_RST       = 4'hF;

    // sizes
    localparam int NUM_PADS       = 10;
    localparam int NUM_SLOTS      = 22;
    localparam int NUM_SHARE      = 15;
    localparam int SEL_W          = 4;
    localparam int SELS_PER_WORD  = 8;
    localparam int GPIO_W         = 24;

    // sharing indices
    localparam int SH_U0_TX   = 0;
    localparam int SH_U0_RX   = 1;
    localparam int SH_U0_CTS  = 2;
    localparam int SH_U0_RTS  = 3;
    localparam int SH_U1_TX   = 4;
    localparam int SH_U1_RX   = 5;
    localparam int SH_TW0_CLK = 6;
    localparam int SH_TW0_DAT = 7;
    localparam int SH_TW1_CLK = 8;
    localparam int SH_TW1_DAT = 9;
    localparam int SH_PWM_LSB = 10;

    // pad functions
    localparam logic [2:0] FN_DEFAULT = 3'h0;
    localparam logic [2:0] FN_GPIO    = 3'h1;
    localparam logic [2:0] FN_DEBUG   = 3'h2;
    localparam logic [2:0] FN_SLOT    = 3'h3;
    localparam logic [2:0] FN_RADIO   = 3'h4;

    // pad order: P00 P01 P02 P12 P13 P15 P16 P17 P22 P23
    localparam int PAD_GPIO [NUM_PADS] = '{0, 1, 2, 12, 13, 15, 16, 17, 22, 23};
    localparam int PAD_SLOT [NUM_PADS] = '{0, 0, 0, 10, 11, 13, 14, 15, 20, 21};
    localparam int PAD12_DBG    = 5;
    localparam int PAD13_DBG    = 6;
    localparam int PAD12_RADIO  = 2;
    localparam int PAD13_RADIO  = 3;
    localparam int PAD15_RADIO  = 5;
    localparam int PAD17_RADIO  = 6;
    localparam int PAD22_RADIO  = 11;

endpackage

/* core/pfm_slot.sv */
`timescale 1ns/1ns
// ****************************************************************
// one shared peripheral slot
// ****************************************************************
module pfm_slot (
    input  wire logic [3:0]  slot_sel,
    input  wire logic        slot_en,
    input  wire logic [14:0] src_out,
    input  wire logic [14:0] src_oe,
    output logic             slot_out,
    output logic             slot_oe
);

    always_comb begin
        slot_out = 1'b0;
        slot_oe  = 1'b0;
        // any listed signal may sit on any slot
        if (slot_en && (slot_sel < 4'(pfm_pkg::NUM_SHARE))) begin
            slot_out = src_out[slot_sel];
            // input-only picks leave the pad undriven
            slot_oe  = src_oe[slot_sel];
        end
    end

endmodule

/* core/pfm_top.sv */
`timescale 1ns/1ns
// ****************************************************************
// ****************************************************************
module pfm_top (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [9:0]  pad_in,
    output logic      [9:0]  pad_out,
    output logic      [9:0]  pad_oe,
    input  wire logic [23:0] gpio_out,
    input  wire logic [23:0] gpio_oe,
    output logic      [23:0] gpio_in,
    output logic             swd_clk_in,
    input  wire logic        swd_data_out,
    input  wire logic        swd_data_oe,
    output logic             swd_data_in,
    input  wire logic        bridge_serial_transmit,
    output logic             bridge_serial_receive,
    input  wire logic [7:0]  link_debug,
    input  wire logic [11:0] radio_test,
    input  wire logic        first_serial_transmit,
    output logic             first_serial_receive,
    output logic             first_serial_clear_to_send,
    input  wire logic        first_serial_request_to_send,
    input  wire logic        second_serial_transmit,
    output logic             second_serial_receive,
    input  wire logic        first_two_wire_clock_out,
    input  wire logic        first_two_wire_clock_oe,
    output logic             first_two_wire_clock_in,
    input  wire logic        first_two_wire_data_out,
    input  wire logic        first_two_wire_data_oe,
    output logic             first_two_wire_data_in,
    input  wire logic        second_two_wire_clock_out,
    input  wire logic        second_two_wire_clock_oe,
    output logic             second_two_wire_clock_in,
    input  wire logic        second_two_wire_data_out,
    input  wire logic        second_two_wire_data_oe,
    output logic             second_two_wire_data_in,
    input  wire logic [4:0]  pulse_width_out
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [2:0] pfm_pick(input logic [4:0] en);
        logic [2:0] idx;
        idx = pfm_pkg::FN_DEFAULT;
        for (int i = 1; i < 5; i++) begin
            if (en[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [31:0] pfm_merge(input logic [31:0] old,
                                              input logic [31:0] wdata,
                                              input logic [3:0]  strb,
                                              input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = wdata[b*8 +: 8];
            end
        end
        return res & mask;
    endfunction

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [31:0] pad_function_enable;
    logic [31:0] shared_slot_enable;
    logic [3:0]  slot_sel [pfm_pkg::NUM_SLOTS];
    logic [31:0] next_prdata;
    logic        addr_hit;
    logic        wr_en;
    logic [31:0] sel_word [3];
    logic [4:0]  fen  [pfm_pkg::NUM_PADS];
    logic [4:0]  fout [pfm_pkg::NUM_PADS];
    logic [4:0]  foe  [pfm_pkg::NUM_PADS];
    logic [2:0]  cur_func [pfm_pkg::NUM_PADS];
    logic [9:0]  next_pad_out;
    logic [9:0]  next_pad_oe;
    logic [14:0] src_out;
    logic [14:0] src_oe;
    logic [9:0]  s_out;
    logic [9:0]  s_oe;
    logic [15:0] share_in;
    logic [29:0] func_state;
    logic [23:0] next_gpio_in;

    // ****************************************************************
    // apb register access
    // ****************************************************************
    always_comb begin
        for (int w = 0; w < 3; w++) begin
            sel_word[w] = 32'h0000_0000;
            for (int k = 0; k < pfm_pkg::SELS_PER_WORD; k++) begin
                if (w * pfm_pkg::SELS_PER_WORD + k < pfm_pkg::NUM_SLOTS) begin
                    sel_word[w][k*4 +: 4] = slot_sel[w * pfm_pkg::SELS_PER_WORD + k];
                end
            end
        end
    end

    always_comb begin
        func_state = 30'h0000_0000;
        for (int p = 0; p < pfm_pkg::NUM_PADS; p++) begin
            func_state[p*3 +: 3] = cur_func[p];
        end
    end

    always_comb begin
        addr_hit    = 1'b1;
        next_prdata = 32'h0000_0000;
        if (paddr == pfm_pkg::ADDR_PAD_FUNC) begin
            next_prdata = pad_function_enable;
        end else if (paddr == pfm_pkg::ADDR_SLOT_EN) begin
            next_prdata = shared_slot_enable;
        end else if (paddr == pfm_pkg::ADDR_SEL_W0) begin
            next_prdata = sel_word[0];
        end else if (paddr == pfm_pkg::ADDR_SEL_W1) begin
            next_prdata = sel_word[1];
        end else if (paddr == pfm_pkg::ADDR_SEL_W2) begin
            next_prdata = sel_word[2];
        end else if (paddr == pfm_pkg::ADDR_PAD_LEVEL) begin
            next_prdata = {22'h00_0000, pad_in};
        end else if (paddr == pfm_pkg::ADDR_PAD_STATE) begin
            next_prdata = {2'b00, func_state};
        end else begin
            addr_hit = 1'b0;
        end
    end

    assign wr_en = psel && penable && pready && pwrite && addr_hit;

    // answer registered in setup cycle, one access cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= !addr_hit;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pad_function_enable <= pfm_pkg::PAD_FUNC_RST;
        end else if (wr_en && paddr == pfm_pkg::ADDR_PAD_FUNC) begin
            pad_function_enable <= pfm_merge(pad_function_enable, pwdata, pstrb,
                                             pfm_pkg::PAD_FUNC_MASK);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shared_slot_enable <= pfm_pkg::SLOT_EN_RST;
        end else if (wr_en && paddr == pfm_pkg::ADDR_SLOT_EN) begin
            shared_slot_enable <= pfm_merge(shared_slot_enable, pwdata, pstrb,
                                            pfm_pkg::SLOT_EN_MASK);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int s = 0; s < pfm_pkg::NUM_SLOTS; s++) begin
                slot_sel[s] <= pfm_pkg::SEL_RST;
            end
        end else if (wr_en) begin
            for (int s = 0; s < pfm_pkg::NUM_SLOTS; s++) begin
                // selector nibble s lives in word s/8, lane s%8
                if ((paddr == pfm_pkg::ADDR_SEL_W0 + 32'(4 * (s / 8)))
                    && pstrb[(s % 8) / 2]) begin
                    slot_sel[s] <= pwdata[(s % 8) * 4 +: 4];
                end
            end
        end
    end

    // ****************************************************************
    // shared signal sources
    // ****************************************************************
    always_comb begin
        src_out = 15'h0000;
        src_oe  = 15'h0000;
        src_out[pfm_pkg::SH_U0_TX]   = first_serial_transmit;
        src_oe[pfm_pkg::SH_U0_TX]    = 1'b1;
        src_out[pfm_pkg::SH_U0_RTS]  = first_serial_request_to_send;
        src_oe[pfm_pkg::SH_U0_RTS]   = 1'b1;
        src_out[pfm_pkg::SH_U1_TX]   = second_serial_transmit;
        src_oe[pfm_pkg::SH_U1_TX]    = 1'b1;
        src_out[pfm_pkg::SH_TW0_CLK] = first_two_wire_clock_out;
        src_oe[pfm_pkg::SH_TW0_CLK]  = first_two_wire_clock_oe;
        src_out[pfm_pkg::SH_TW0_DAT] = first_two_wire_data_out;
        src_oe[pfm_pkg::SH_TW0_DAT]  = first_two_wire_data_oe;
        src_out[pfm_pkg::SH_TW1_CLK] = second_two_wire_clock_out;
        src_oe[pfm_pkg::SH_TW1_CLK]  = second_two_wire_clock_oe;
        src_out[pfm_pkg::SH_TW1_DAT] = second_two_wire_data_out;
        src_oe[pfm_pkg::SH_TW1_DAT]  = second_two_wire_data_oe;
        for (int i = 0; i < 5; i++) begin
            src_out[pfm_pkg::SH_PWM_LSB + i] = pulse_width_out[i];
            src_oe[pfm_pkg::SH_PWM_LSB + i]  = 1'b1;
        end
    end

    assign s_out[1:0] = 2'b00;
    assign s_oe[1:0]  = 2'b00;

    for (genvar g = 2; g < pfm_pkg::NUM_PADS; g++) begin : g_slot
        pfm_slot u_slot (
            .slot_sel (slot_sel[pfm_pkg::PAD_SLOT[g]]),
            .slot_en  (shared_slot_enable[pfm_pkg::PAD_SLOT[g]]),
            .src_out  (src_out),
            .src_oe   (src_oe),
            .slot_out (s_out[g]),
            .slot_oe  (s_oe[g])
        );
    end

    // ****************************************************************
    // pad function tables
    // ****************************************************************
    logic rf_en;
    assign rf_en = pad_function_enable[pfm_pkg::RADIO_BIT];

    always_comb begin
        for (int p = 0; p < pfm_pkg::NUM_PADS; p++) begin
            fen[p]  = 5'b00001;
            fout[p] = 5'b00000;
            foe[p]  = 5'b00000;
        end
        // pad0: debug clock input is never driven
        fen[0]  = {3'b000, pad_function_enable[pfm_pkg::PAD0_GIO_BIT], 1'b1};
        fout[0] = {3'b000, gpio_out[0], 1'b0};
        foe[0]  = {3'b000, gpio_oe[0], 1'b0};
        fen[1]  = {3'b000, pad_function_enable[pfm_pkg::PAD1_GIO_BIT], 1'b1};
        fout[1] = {3'b000, gpio_out[1], swd_data_out};
        foe[1]  = {3'b000, gpio_oe[1], swd_data_oe};
        fen[2]  = {1'b0, shared_slot_enable[pfm_pkg::PAD_SLOT[2]], 3'b001};
        fout[2] = {1'b0, s_out[2], 2'b00, gpio_out[2]};
        foe[2]  = {1'b0, s_oe[2], 2'b00, gpio_oe[2]};
        fen[3]  = {rf_en, shared_slot_enable[pfm_pkg::PAD_SLOT[3]],
                   pad_function_enable[pfm_pkg::DBG_LSB + pfm_pkg::PAD12_DBG],
                   pad_function_enable[pfm_pkg::PAD12_GIO_BIT], 1'b1};
        fout[3] = {radio_test[pfm_pkg::PAD12_RADIO], s_out[3],
                   link_debug[pfm_pkg::PAD12_DBG], gpio_out[12], bridge_serial_transmit};
        foe[3]  = {1'b1, s_oe[3], 1'b1, gpio_oe[12], 1'b1};
        fen[4]  = {rf_en, shared_slot_enable[pfm_pkg::PAD_SLOT[4]],
                   pad_function_enable[pfm_pkg::DBG_LSB + pfm_pkg::PAD13_DBG],
                   pad_function_enable[pfm_pkg::PAD13_GIO_BIT], 1'b1};
        fout[4] = {radio_test[pfm_pkg::PAD13_RADIO], s_out[4],
                   link_debug[pfm_pkg::PAD13_DBG], gpio_out[13], 1'b0};
        foe[4]  = {1'b1, s_oe[4], 1'b1, gpio_oe[13], 1'b0};
        // pads 15..23: general IO first, slot, radio where offered
        for (int p = 5; p < pfm_pkg::NUM_PADS; p++) begin
            fen[p]  = {1'b0, shared_slot_enable[pfm_pkg::PAD_SLOT[p]], 3'b001};
            fout[p] = {1'b0, s_out[p], 2'b00, gpio_out[pfm_pkg::PAD_GPIO[p]]};
            foe[p]  = {1'b0, s_oe[p], 2'b00, gpio_oe[pfm_pkg::PAD_GPIO[p]]};
        end
        fen[5][4]  = rf_en;
        fout[5][4] = radio_test[pfm_pkg::PAD15_RADIO];
        foe[5][4]  = 1'b1;
        fen[7][4]  = rf_en;
        fout[7][4] = radio_test[pfm_pkg::PAD17_RADIO];
        foe[7][4]  = 1'b1;
        fen[8][4]  = rf_en;
        fout[8][4] = radio_test[pfm_pkg::PAD22_RADIO];
        foe[8][4]  = 1'b1;
    end

    always_comb begin
        for (int p = 0; p < pfm_pkg::NUM_PADS; p++) begin
            cur_func[p]     = pfm_pick(fen[p]);
            next_pad_out[p] = fout[p][cur_func[p]];
            next_pad_oe[p]  = foe[p][cur_func[p]];
        end
    end

    // ****************************************************************
    // input routing
    // ****************************************************************
    always_comb begin
        // idle high for serial and two-wire lines
        share_in = 16'hFFFF;
        // lowest pad wins when two slots pick one input
        for (int p = pfm_pkg::NUM_PADS - 1; p >= 2; p--) begin
            if (cur_func[p] == pfm_pkg::FN_SLOT) begin
                share_in[slot_sel[pfm_pkg::PAD_SLOT[p]]] = pad_in[p];
            end
        end
    end

    always_comb begin
        next_gpio_in = 24'h00_0000;
        for (int p = 0; p < pfm_pkg::NUM_PADS; p++) begin
            next_gpio_in[pfm_pkg::PAD_GPIO[p]] = pad_in[p];
        end
    end

    // ****************************************************************
    // registered outputs
    // ****************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pad_out <= 10'h000;
            pad_oe  <= 10'h000;
        end else begin
            pad_out <= next_pad_out;
            pad_oe  <= next_pad_oe;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gpio_in               <= 24'h00_0000;
            swd_clk_in            <= 1'b0;
            swd_data_in           <= 1'b1;
            bridge_serial_receive <= 1'b1;
        end else begin
            gpio_in               <= next_gpio_in;
            swd_clk_in            <= (cur_func[0] == pfm_pkg::FN_DEFAULT) && pad_in[0];
            swd_data_in           <= (cur_func[1] == pfm_pkg::FN_DEFAULT) ? pad_in[1] : 1'b1;
            bridge_serial_receive <= (cur_func[4] == pfm_pkg::FN_DEFAULT) ? pad_in[4] : 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            first_serial_receive       <= 1'b1;
            first_serial_clear_to_send <= 1'b1;
            second_serial_receive      <= 1'b1;
            first_two_wire_clock_in    <= 1'b1;
            first_two_wire_data_in     <= 1'b1;
            second_two_wire_clock_in   <= 1'b1;
            second_two_wire_data_in    <= 1'b1;
        end else begin
            first_serial_receive       <= share_in[pfm_pkg::SH_U0_RX];
            first_serial_clear_to_send <= share_in[pfm_pkg::SH_U0_CTS];
            second_serial_receive      <= share_in[pfm_pkg::SH_U1_RX];
            first_two_wire_clock_in    <= share_in[pfm_pkg::SH_TW0_CLK];
            first_two_wire_data_in     <= share_in[pfm_pkg::SH_TW0_DAT];
            second_two_wire_clock_in   <= share_in[pfm_pkg::SH_TW1_CLK];
            second_two_wire_data_in    <= share_in[pfm_pkg::SH_TW1_DAT];
        end
    end

endmodule

/* tb/pfm_sva.sv */
`timescale 1ns/1ns
// ********
// port checker
// ********
module pfm_sva (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic [9:0]  pad_in,
    input wire logic [23:0] gpio_in,
    input wire logic        swd_clk_in,
    input wire logic        swd_data_in,
    input wire logic        bridge_serial_receive
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready too long");
    ready_cause_a: assert property (pready |-> $past(psel && !penable))
        else $error("ready without setup");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error answer");
    swclk_follow_a: assert property (swd_clk_in |-> $past(pad_in[0]))
        else $error("debug clock not from pad");
    swdio_follow_a: assert property (!swd_data_in |-> !$past(pad_in[1]))
        else $error("debug data not from pad");
    bridge_rx_a: assert property (!bridge_serial_receive |-> !$past(pad_in[4]))
        else $error("bridge receive not from pad");
    gpio_route_a: assert property (!$past(rst) |-> gpio_in[13:12] == $past(pad_in[4:3]))
        else $error("gpio level not routed");
    gpio_unused_a: assert property (gpio_in[11:3] == 9'h0 && gpio_in[21:18] == 4'h0)
        else $error("unused gpio bit set");
endmodule

/* tb/pfm_pad_model.sv */
`timescale 1ns/1ns
// ********
// pads and outside world
// ********
module pfm_pad_model (
    input  wire logic       ref_clk,
    input  wire logic [9:0] pad_out,
    input  wire logic [9:0] pad_oe,
    input  wire logic [9:0] ext_val,
    input  wire logic [9:0] ext_en,
    output logic      [9:0] pad_in
);
    logic tgl = 1'b0;
    // pads with neither pad_oe nor ext_en set change every cycle
    always @(posedge ref_clk) begin
        tgl <= ~tgl;
    end
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            pad_in[i] = pad_oe[i] ? pad_out[i] : (ext_en[i] ? ext_val[i] : tgl);
        end
    end
endmodule

/* tb/pad_function_mux_tb_top.sv */
`timescale 1ns/1ns
// ********
// bench
// ********
module pad_function_mux_tb_top;
    typedef struct { logic [31:0] w0, w1; logic [9:0] oe, out; } pfm_row_t;
    logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, e;
    logic [31:0] paddr, pwdata, prdata, q;
    logic [3:0]  pstrb;
    logic [9:0]  pad_in, pad_out, pad_oe, ext_val, ext_en;
    logic [23:0] gpio_out, gpio_oe, gpio_in;
    logic [7:0]  link_debug;
    logic [11:0] radio_test;
    logic [4:0]  pulse_width_out;
    logic        swd_clk_in, swd_data_out, swd_data_oe, swd_data_in;
    logic        bridge_serial_transmit, bridge_serial_receive;
    logic        first_serial_transmit, first_serial_receive, first_serial_clear_to_send;
    logic        first_serial_request_to_send, second_serial_transmit, second_serial_receive;
    logic        tw0c_o, tw0c_e, tw0c_i, tw0d_o, tw0d_e, tw0d_i;
    logic        tw1c_o, tw1c_e, tw1c_i, tw1d_o, tw1d_e, tw1d_i;
    int          errors, num_checks;
    localparam logic [14:0] OEX  = 15'h7ED9;
    localparam logic [14:0] OUTX = 15'h2851;
    pfm_row_t rows [8] = '{
        '{32'h0000_0000, 32'h0000_0000, 10'h3EE, 10'h00A},
        '{32'h0000_1E00, 32'h0000_0000, 10'h3FF, 10'h000},
        '{32'h0060_1E00, 32'h0000_0000, 10'h3FF, 10'h018},
        '{32'h0060_1E00, 32'h0030_EC01, 10'h003, 10'h000},
        '{32'h0060_3E00, 32'h0030_EC01, 10'h1BB, 10'h1A0},
        '{32'h0000_2000, 32'h0000_0000, 10'h3FE, 10'h1A2},
        '{32'h009F_0000, 32'h0000_0000, 10'h3EE, 10'h00A},
        '{32'h0000_1000, 32'h0000_0000, 10'h3FE, 10'h00A}};
    pfm_top i_dut (
        .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .pad_in, .pad_out, .pad_oe, .gpio_out, .gpio_oe, .gpio_in, .swd_clk_in,
        .swd_data_out, .swd_data_oe, .swd_data_in, .bridge_serial_transmit,
        .bridge_serial_receive, .link_debug, .radio_test, .first_serial_transmit,
        .first_serial_receive, .first_serial_clear_to_send, .first_serial_request_to_send,
        .second_serial_transmit, .second_serial_receive, .pulse_width_out,
        .first_two_wire_clock_out(tw0c_o), .first_two_wire_clock_oe(tw0c_e),
        .first_two_wire_clock_in(tw0c_i), .first_two_wire_data_out(tw0d_o),
        .first_two_wire_data_oe(tw0d_e), .first_two_wire_data_in(tw0d_i),
        .second_two_wire_clock_out(tw1c_o), .second_two_wire_clock_oe(tw1c_e),
        .second_two_wire_clock_in(tw1c_i), .second_two_wire_data_out(tw1d_o),
        .second_two_wire_data_oe(tw1d_e), .second_two_wire_data_in(tw1d_i));
    pfm_pad_model i_pads (.ref_clk, .pad_out, .pad_oe, .ext_val, .ext_en, .pad_in);
    task automatic wrap_up;
        if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            errors++;
            wrap_up();
        end
    endtask
    task automatic rd(input string name, input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, exp, q);
    endtask
    task automatic settle;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    function automatic logic rx(input int i);
        case (i)
            1: return first_serial_receive;
            2: return first_serial_clear_to_send;
            5: return second_serial_receive;
            6: return tw0c_i;
            7: return tw0d_i;
            8: return tw1c_i;
            default: return tw1d_i;
        endcase
    endfunction
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata, pstrb} = {3'b100, 65'h0, 4'hF};
        {gpio_out, gpio_oe, swd_data_out, swd_data_oe} = {24'h0, 24'hFFFFFF, 2'b11};
        {bridge_serial_transmit, link_debug, radio_test} = {1'b1, 8'hFF, 12'h860};
        {first_serial_transmit, first_serial_request_to_send, second_serial_transmit} = 3'b101;
        {tw0c_o, tw0c_e, tw0d_o, tw0d_e, tw1c_o, tw1c_e, tw1d_o, tw1d_e} = 8'b11011001;
        {pulse_width_out, ext_val, ext_en, errors, num_checks} = {5'h0A, 10'h3F7, 10'h1FF, 64'h0};
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        rd("pad_func", pfm_pkg::ADDR_PAD_FUNC, 32'h0);
        rd("slot_en", pfm_pkg::ADDR_SLOT_EN, 32'h0);
        rd("sel_w0", pfm_pkg::ADDR_SEL_W0, 32'hFFFF_FFFF);
        rd("sel_w2", pfm_pkg::ADDR_SEL_W2, 32'h00FF_FFFF);
        apb(1'b1, pfm_pkg::ADDR_PAD_FUNC, 32'hFFFF_FFFF);
        rd("pad_func", pfm_pkg::ADDR_PAD_FUNC, 32'h00FF_3E00);
        apb(1'b1, pfm_pkg::ADDR_SLOT_EN, 32'hFFFF_FFFF);
        rd("slot_en", pfm_pkg::ADDR_SLOT_EN, 32'h003F_FFFF);
        apb(1'b1, 32'h2013_2040, 32'h1);
        chk("slverr", 32'h1, 32'(e));
        foreach (rows[i]) begin
            apb(1'b1, pfm_pkg::ADDR_PAD_FUNC, rows[i].w0);
            apb(1'b1, pfm_pkg::ADDR_SLOT_EN, rows[i].w1);
            settle();
            chk("pad_oe", 32'(rows[i].oe), 32'(pad_oe));
            chk("pad_out", 32'(rows[i].out), 32'(pad_out & rows[i].oe));
        end
        apb(1'b1, pfm_pkg::ADDR_PAD_FUNC, 32'h0);
        apb(1'b1, pfm_pkg::ADDR_SLOT_EN, 32'h400);
        for (int i = 0; i < 15; i++) begin
            apb(1'b1, pfm_pkg::ADDR_SEL_W1, 32'hFFFF_F0FF | (32'(i) << 8));
            settle();
            chk("slot_oe", 32'(OEX[i]), 32'(pad_oe[3]));
            if (OEX[i]) chk("slot_out", 32'(OUTX[i]), 32'(pad_out[3]));
            else chk("slot_in", 32'h0, 32'(rx(i)));
            if (i >= 6 && i <= 9) chk("tw_in", 32'(OEX[i] & OUTX[i]), 32'(rx(i)));
        end
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk("rst_oe", 32'h0, 32'(pad_oe));
        rst <= 1'b0;
        rd("sel_w1", pfm_pkg::ADDR_SEL_W1, 32'hFFFF_FFFF);
        settle();
        chk("pad_oe", 32'h3EE, 32'(pad_oe));
        pstrb <= 4'h4;
        apb(1'b1, pfm_pkg::ADDR_PAD_FUNC, 32'hFFFF_FFFF);
        pstrb <= 4'hF;
        rd("pad_func", pfm_pkg::ADDR_PAD_FUNC, 32'h00FF_0000);
        wrap_up();
    end
endmodule
bind pfm_top pfm_sva i_sva (.ref_clk, .rst, .psel, .penable, .pready, .pslverr, .prdata,
    .pad_in, .gpio_in, .swd_clk_in, .swd_data_in, .bridge_serial_receive);
